// ### core/uhrs_pkg.sv
package uhrs_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] HOST_COMMAND_OFS = 8'h20;
    localparam logic [7:0] HOST_STATUS_OFS = 8'h24;

    // ==========================================
    // host_command fields
    localparam int CMD_RUN_BIT = 0;
    localparam int CMD_RESET_BIT = 1;
    localparam int CMD_FLS_LSB = 2;
    localparam logic [1:0] FLS_1024 = 2'h0;
    localparam logic [1:0] FLS_512 = 2'h1;
    localparam logic [1:0] FLS_256 = 2'h2;
    localparam logic [1:0] FLS_RSVD = 2'h3;
    localparam logic [1:0] FLS_RESET = FLS_1024;
    localparam logic [10:0] ENTRIES_1024 = 11'h400;
    localparam logic [10:0] ENTRIES_512 = 11'h200;
    localparam logic [10:0] ENTRIES_256 = 11'h100;

    // ==========================================
    // host_status fields
    localparam int EVENT_BITS = 6;
    localparam int STS_HALTED_BIT = 12;
    localparam logic [EVENT_BITS-1:0] EVENTS_RESET = 6'h00;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SOFT_RESET_NS = 1600;
    localparam int SOFT_RESET_CYCLES_INT =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SOFT_RESET_CYCLES = 5'(SOFT_RESET_CYCLES_INT);

    // ==========================================
    // run/halt state, gray along halted-running-stopping
    typedef enum logic [1:0] {
        UHRS_HALTED = 2'h0,
        UHRS_RUNNING = 2'h1,
        UHRS_STOPPING = 2'h3
    } uhrs_run_t;
endpackage : uhrs_pkg

// ### core/uhrs_top.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RL1] code 10b gives 256; 11b refused
// [RL2] soft reset clears all internal state
// [RL3] soft reset aborts transaction in progress
// [RL4] soft reset drives no port bus reset
// [RL5] pci configuration space left untouched
// [RL6] operational and port registers reinitialised
// [RL7] port ownership returns to companion controller
// [RL8] reset bit self-clears when sequence ends
// [RL9] writing zero cannot cut reset short
// [RL10] software reprograms controller after soft reset
// [RL11] software checks halted flag before reset
// [RL12] resetting running controller is undefined
// [RL13] run set keeps schedules executing
// [RL14] run cleared: drain pipeline, halt, flag
// [RL15] software sees halted before setting run
// [RL16] status shows only interrupts and states
// [RL17] status bits clear on write one
// [RL18] status at 24h, bits 31:24 zero
// [RL19] 00b 1024 entries, 01b 512, reset 00b
// [RL20] size writable only with programmable flag
// [RL21] reset bit reads one whole sequence
module uhrs_top import uhrs_pkg::*; (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic programmable_list_flag_i,
    input wire logic pipeline_busy_i,
    input wire logic [EVENT_BITS-1:0] status_event_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic schedule_run_o,
    output logic halted_flag_o,
    output logic [1:0] frame_list_size_o,
    output logic [10:0] frame_list_entries_o,
    output logic soft_reset_o,
    output logic transaction_abort_o,
    output logic port_owner_companion_o,
    output logic port_bus_reset_o
);

    // ==========================================
    // state
    typedef struct packed {
        logic run_stop_control;
        logic [1:0] frame_list_size;
        logic controller_soft_reset;
        logic [4:0] reset_count;
        uhrs_run_t run_state;
        logic [EVENT_BITS-1:0] events;
        logic [31:0] rdata;
        logic rvalid;
        logic abort;
        logic companion;
        logic [10:0] entries;
        logic halted;
        logic sched;
        logic bus_reset;
    } uhrs_state_t;

    localparam uhrs_state_t STATE_RESET = '{
        run_stop_control: 1'b0,
        frame_list_size: FLS_RESET,
        controller_soft_reset: 1'b0,
        reset_count: 5'h00,
        run_state: UHRS_HALTED,
        events: EVENTS_RESET,
        rdata: 32'h0000_0000,
        rvalid: 1'b0,
        abort: 1'b0,
        // companion owns the ports after any reset [RL7]
        companion: 1'b1,
        entries: ENTRIES_1024,
        halted: 1'b1,
        sched: 1'b0,
        // kept as a flop so every output is registered
        bus_reset: 1'b0
    };

    uhrs_state_t state;
    uhrs_state_t next_state;

    // ==========================================
    // next state
    always_comb begin
        logic cmd_wr;
        logic sts_wr;
        logic rst_req;
        logic fls_ok;
        logic [1:0] fls_req;
        logic [31:0] cmd_view;
        logic [31:0] sts_view;

        cmd_wr = reg_wr_i && (reg_addr_i == HOST_COMMAND_OFS);
        sts_wr = reg_wr_i && (reg_addr_i == HOST_STATUS_OFS);
        rst_req = cmd_wr && reg_wdata_i[CMD_RESET_BIT];
        fls_req = reg_wdata_i[CMD_FLS_LSB +: 2];
        // reserved code would leave the frame index width undefined [RL1]
        fls_ok = programmable_list_flag_i && (fls_req != FLS_RSVD); // [RL20]
        cmd_view = 32'h0000_0000;
        sts_view = 32'h0000_0000; // [RL18]
        next_state = state;
        next_state.abort = 1'b0;

        if (state.controller_soft_reset) begin
            // hold everything at initial values; writes of zero are ignored [RL9]
            // only operational state lives here, config space is elsewhere [RL5]
            next_state = STATE_RESET; // [RL2] [RL6]
            next_state.controller_soft_reset = 1'b1; // [RL21]
            next_state.reset_count = state.reset_count + 5'h01;
            if (state.reset_count == SOFT_RESET_CYCLES - 5'h01) begin
                next_state.controller_soft_reset = 1'b0; // [RL8]
                next_state.reset_count = 5'h00;
            end
        end else if (rst_req) begin
            // undefined if running; we simply abort and reset anyway
            next_state = STATE_RESET; // [RL2] [RL6]
            next_state.controller_soft_reset = 1'b1; // [RL21]
            // abort lasts one cycle; the drain is not waited for
            next_state.abort = 1'b1; // [RL3]
            next_state.companion = 1'b1; // [RL7]
        end else begin
            if (cmd_wr) begin
                next_state.run_stop_control = reg_wdata_i[CMD_RUN_BIT];
                if (fls_ok) begin // [RL20] [RL1]
                    next_state.frame_list_size = fls_req;
                end
            end
            // set wins over a concurrent write-one clear [RL17]
            for (int i = 0; i < EVENT_BITS; i++) begin
                if (status_event_i[i]) begin
                    next_state.events[i] = 1'b1;
                end else if (sts_wr && reg_wdata_i[i]) begin
                    next_state.events[i] = 1'b0;
                end
            end
            case (state.run_state)
                UHRS_HALTED: begin
                    if (next_state.run_stop_control) begin
                        next_state.run_state = UHRS_RUNNING; // [RL13]
                    end
                end
                UHRS_RUNNING: begin
                    if (!next_state.run_stop_control) begin
                        next_state.run_state = UHRS_STOPPING; // [RL14]
                    end
                end
                UHRS_STOPPING: begin
                    // pipeline drains before halted rises
                    // a run write while stopping waits for the halt first
                    if (!pipeline_busy_i) begin
                        next_state.run_state = UHRS_HALTED; // [RL14]
                    end
                end
                default: begin
                    next_state.run_state = UHRS_HALTED;
                end
            endcase
        end

        // flags follow run_state in the same cycle, from flops
        next_state.halted = (next_state.run_state == UHRS_HALTED); // [RL14]
        next_state.sched = (next_state.run_state != UHRS_HALTED); // [RL13]
        next_state.bus_reset = 1'b0; // [RL4]

        // entries follow the size in the same cycle
        case (next_state.frame_list_size)
            FLS_512: next_state.entries = ENTRIES_512; // [RL19]
            FLS_256: next_state.entries = ENTRIES_256; // [RL1]
            default: next_state.entries = ENTRIES_1024; // [RL19]
        endcase

        // read view; only interrupt causes and controller state appear [RL16]
        // a read in the cycle of a write returns the old value
        cmd_view[CMD_RUN_BIT] = state.run_stop_control;
        cmd_view[CMD_RESET_BIT] = state.controller_soft_reset; // [RL21]
        cmd_view[CMD_FLS_LSB +: 2] = state.frame_list_size;
        sts_view[EVENT_BITS-1:0] = state.events;
        sts_view[STS_HALTED_BIT] = state.halted;
        // reads stay valid during soft reset; unmapped offsets read zero
        next_state.rvalid = reg_rd_i;
        next_state.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == HOST_COMMAND_OFS) begin
                next_state.rdata = cmd_view;
            end else if (reg_addr_i == HOST_STATUS_OFS) begin
                next_state.rdata = sts_view; // [RL18]
            end
        end
    end

    // ==========================================
    // registers
    // chip reset and soft reset share one reset image
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // outputs
    assign reg_rdata_o = state.rdata;
    assign reg_rvalid_o = state.rvalid;
    assign schedule_run_o = state.sched;
    assign halted_flag_o = state.halted; // [RL14]
    assign frame_list_size_o = state.frame_list_size;
    assign frame_list_entries_o = state.entries;
    assign soft_reset_o = state.controller_soft_reset;
    assign transaction_abort_o = state.abort; // [RL3]
    assign port_owner_companion_o = state.companion; // [RL7]
    // soft reset never reaches the port reset signalling [RL4]
    assign port_bus_reset_o = state.bus_reset;

endmodule : uhrs_top

`default_nettype wire

// ### testbench/uhrs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker
module uhrs_assertions import uhrs_pkg::*; (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic pipeline_busy_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic halted_flag_o,
    input wire logic schedule_run_o,
    input wire logic [1:0] frame_list_size_o,
    input wire logic [10:0] frame_list_entries_o,
    input wire logic soft_reset_o,
    input wire logic transaction_abort_o,
    input wire logic port_owner_companion_o,
    input wire logic port_bus_reset_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_reset_run;
        soft_reset_o [*8] ##1 soft_reset_o [*8] ##1 !soft_reset_o;
    endsequence
    a_reset_len: assert property ($rose(soft_reset_o) |-> s_reset_run)
        else $error("soft reset length wrong");
    a_abort_pulse: assert property ($rose(soft_reset_o) |-> transaction_abort_o ##1 !transaction_abort_o)
        else $error("abort pulse missing");
    a_reset_state: assert property ($rose(soft_reset_o) |->
        halted_flag_o && !schedule_run_o && frame_list_size_o == FLS_RESET)
        else $error("state not reinitialised");
    a_no_bus_reset: assert property (port_bus_reset_o == 1'b0)
        else $error("bus reset driven");
    a_port_owner: assert property (port_owner_companion_o)
        else $error("ports not with companion");
    a_size_decode: assert property (frame_list_size_o != FLS_RSVD && frame_list_entries_o ==
        (frame_list_size_o == FLS_512 ? ENTRIES_512 :
        frame_list_size_o == FLS_256 ? ENTRIES_256 : ENTRIES_1024))
        else $error("frame list size decode wrong");
    a_halt_drain: assert property ($rose(halted_flag_o) && !soft_reset_o |->
        !$past(pipeline_busy_i))
        else $error("halted before drain");
    a_run_halt: assert property (halted_flag_o != schedule_run_o)
        else $error("run and halted disagree");
    a_status_top: assert property (reg_rd_i && reg_addr_i == HOST_STATUS_OFS |=>
        reg_rdata_o[31:24] == 8'h00)
        else $error("status reserved bits set");
endmodule : uhrs_assertions
bind uhrs_top uhrs_assertions i_uhrs_assertions (.*);
`default_nettype wire

// ### testbench/uhrs_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// pipeline drains a fixed count after stop, never instantly
module uhrs_pipe_model #(parameter logic [3:0] DRAIN = 4'h5) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic schedule_run_i,
    input wire logic stop_i,
    output logic pipeline_busy_o
);
    logic [3:0] cnt;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) cnt <= DRAIN;
        else if (!stop_i) cnt <= DRAIN;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign pipeline_busy_o = schedule_run_i && cnt != 4'h0;
endmodule : uhrs_pipe_model
`default_nettype wire

// ### testbench/usb_host_run_reset_status_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench
module usb_host_run_reset_status_bench import uhrs_pkg::*; ;
    logic clock_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, stop_i = 0;
    logic programmable_list_flag_i = 0, pipeline_busy_i;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [5:0] status_event_i = 6'h00;
    logic reg_rvalid_o, schedule_run_o, halted_flag_o, soft_reset_o;
    logic transaction_abort_o, port_owner_companion_o, port_bus_reset_o;
    logic [1:0] frame_list_size_o;
    logic [10:0] frame_list_entries_o;
    int error_cnt = 0, num_checks = 0, i;
    localparam logic [7:0] CMD = HOST_COMMAND_OFS, STS = HOST_STATUS_OFS;
    uhrs_top i_uhrs_top (.*);
    uhrs_pipe_model i_uhrs_pipe_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .schedule_run_i(schedule_run_o), .stop_i(stop_i), .pipeline_busy_o(pipeline_busy_i));
    always #50 clock_i = ~clock_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock_i); reg_wr_i = 1; reg_addr_i = a; reg_wdata_i = d;
        @(negedge clock_i); reg_wr_i = 0;
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(negedge clock_i); reg_rd_i = 1; reg_addr_i = a;
        @(negedge clock_i); reg_rd_i = 0;
        chk(reg_rdata_o, e);
        chk({31'h0, reg_rvalid_o}, 32'h1);
    endtask : rdc
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        #(2000 * 100);
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (4) @(negedge clock_i);
        reset_n_i = 1;
        rdc(STS, 32'h0000_1000);
        rdc(CMD, 32'h0);
        rdc(8'h28, 32'h0);
        wr(CMD, 32'h4); rdc(CMD, 32'h0);
        programmable_list_flag_i = 1;
        for (i = 0; i < 3; i++) begin
            wr(CMD, i << 2); rdc(CMD, i << 2);
            chk(32'(frame_list_entries_o), 32'h400 >> i);
            chk(32'(frame_list_size_o), 32'(i));
        end
        wr(CMD, 32'hC); rdc(CMD, 32'h8);
        $display("test size done");
        @(negedge clock_i); status_event_i = 6'h15;
        @(negedge clock_i); status_event_i = 6'h00;
        wr(STS, 32'hFF00_0000); rdc(STS, 32'h0000_1015);
        wr(STS, 32'h1); rdc(STS, 32'h0000_1014);
        @(negedge clock_i); status_event_i = 6'h04; reg_wr_i = 1; reg_addr_i = STS;
        reg_wdata_i = 32'h4;
        @(negedge clock_i); status_event_i = 6'h00; reg_wr_i = 0;
        rdc(STS, 32'h0000_1014);
        $display("test status done");
        wr(CMD, 32'h9); @(negedge clock_i);
        chk(32'(schedule_run_o), 32'h1); rdc(STS, 32'h14);
        stop_i = 1; wr(CMD, 32'h8);
        for (i = 0; i < 20 && !halted_flag_o; i++) @(negedge clock_i);
        chk(32'(i > 3 && i < 20), 32'h1); rdc(STS, 32'h1014);
        chk(32'(halted_flag_o), 32'h1);
        stop_i = 0;
        $display("test run done");
        wr(CMD, 32'hA); chk(32'(transaction_abort_o), 32'h1);
        wr(CMD, 32'h0); rdc(CMD, 32'h2);
        chk(32'(soft_reset_o), 32'h1);
        for (i = 0; i < 40 && soft_reset_o; i++) @(negedge clock_i);
        chk(32'(i), 32'(SOFT_RESET_CYCLES_INT - 4));
        rdc(CMD, 32'h0); rdc(STS, 32'h1000);
        chk(32'({port_owner_companion_o, port_bus_reset_o}), 32'h2);
        wr(CMD, 32'h4); rdc(CMD, 32'h4);
        $display("test soft reset done");
        give_verdict;
    end
endmodule : usb_host_run_reset_status_bench
`default_nettype wire
